// *** hdl/adc_regs_pkg.sv ***
// Package: register map, field positions, reset values for the converter
// register bank. Assumes a 32-bit AXI4-Lite slave with word-aligned byte offsets.
package adc_regs_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // Byte offsets on the bus
  localparam logic [7:0] OFS_COMMAND  = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_RESULT_IN = 8'h08;
  localparam logic [7:0] OFS_SESSION  = 8'h0C;

  // Target register select codes (command bits 3:0)
  localparam logic [3:0] SEL_COMMAND = 4'h0;
  localparam logic [3:0] SEL_STATUS  = 4'h0;
  localparam logic [3:0] SEL_MODE    = 4'h1;
  localparam logic [3:0] SEL_CHANNEL = 4'h2;
  localparam logic [3:0] SEL_FILTER  = 4'h3;
  localparam logic [3:0] SEL_RESULT  = 4'h4;
  localparam logic [3:0] SEL_OFFSET  = 4'h5;
  localparam logic [3:0] SEL_GAIN    = 4'h6;
  localparam logic [3:0] SEL_PORT    = 4'h7;
  localparam logic [3:0] SEL_TEST1   = 4'hC;
  localparam logic [3:0] SEL_TEST2   = 4'hD;
  localparam logic [3:0] SEL_ID      = 4'hF;

  // Command register fields
  localparam int unsigned CMD_WEN_BIT = 7;
  localparam int unsigned CMD_RD_BIT  = 6;

  // Mode register: fully differential when mode bit 4 clear
  localparam int unsigned MODE_PSEUDO_BIT = 4;
  // Channel control: channel in 7:4
  localparam int unsigned CH_SEL_LSB = 4;

  // Reset values
  localparam logic [7:0]  RST_STATUS  = 8'h00;
  localparam logic [7:0]  RST_MODE    = 8'h00;
  localparam logic [7:0]  RST_CHANNEL = 8'h07;
  localparam logic [7:0]  RST_PORT    = 8'h00;
  localparam logic [7:0]  RST_FILTER  = 8'h45;
  localparam logic [23:0] RST_RESULT  = 24'h000000;
  localparam logic [23:0] RST_OFFSET  = 24'h800000;
  localparam logic [23:0] RST_GAIN    = 24'h500000;
  localparam logic [23:0] RST_TEST    = 24'h000000;
  localparam logic [7:0]  FILTER_MIN  = 8'h03;

  localparam int unsigned NUM_CAL = 5;

  // Response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Session bit: 1 while waiting for a command write
  localparam int unsigned SES_WAIT_BIT = 0;

endpackage

// *** hdl/cal_bank.sv ***
// Calibration coefficient bank: offset or gain words, one per differential
// channel pair. Assumes the caller picks the slot from the channel.
`timescale 1ns/1ps
module cal_bank
  import adc_regs_pkg::*;
#(
  parameter int unsigned DEPTH = NUM_CAL,
  parameter logic [23:0] RESET_WORD = RST_OFFSET
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  slot,
  input  wire logic        wr_en,
  input  wire logic [23:0] wr_word,
  output logic      [23:0] rd_word
);

  // Slot select is three bits wide, so at most eight words
  if (DEPTH < 1 || DEPTH > 8) begin : g_depth_check
    $error("cal_bank depth out of range");
  end

  logic [23:0] word_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (sys_rst) begin
        word_q[i] <= RESET_WORD;
      end else if (wr_en && slot == i[2:0]) begin
        word_q[i] <= wr_word;
      end
    end
  end

  // Out-of-range slot reads the last word rather than garbage
  always_comb begin
    rd_word = word_q[DEPTH-1];
    for (int i = 0; i < DEPTH; i++) begin
      if (slot == i[2:0]) begin
        rd_word = word_q[i];
      end
    end
  end

endmodule // cal_bank

// *** hdl/adc_register_map_control.sv ***
// Register bank of a multichannel converter, reached through one command
// word and one data window over AXI4-Lite.
// Assumes a single clock and one read and one write outstanding at most.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module adc_register_map_control
  import adc_regs_pkg::*;
#(
  parameter logic [7:0] SILICON_ID = 8'h5A  // Arbitrary value
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [23:0]           conv_result,
  input  wire logic                  conv_valid,
  input  wire logic [7:0]            status_in,
  output logic [7:0]                 mode_q,
  output logic [7:0]                 channel_q,
  output logic [7:0]                 port_q,
  output logic [7:0]                 decimation_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus channel capture

  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic                  aw_held_q;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [3:0]            wstrb_q;
  logic                  w_held_q;
  logic                  wr_go;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      aw_held_q     <= 1'b0;
      awaddr_q      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      s_axi_awready <= !aw_held_q && !s_axi_awready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b0;
      w_held_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else begin
      if (wr_go) begin
        w_held_q <= 1'b0;
      end
      s_axi_wready <= !w_held_q && !s_axi_wready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command session state

  typedef enum logic [1:0] {
    WAIT_CMD,
    WAIT_WRITE,
    WAIT_READ
  } session_t;

  session_t   state_q;
  logic [3:0] target_q;

  // Word address decode, shared by the session logic, register updates and read path
  function automatic logic is_word(input logic [AXI_ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic [AXI_ADDR_W-1:0] rd_addr;

  // Command occupies byte lane 0; other lanes do not form a command
  assign cmd_wr  = wr_go && is_word(awaddr_q, OFS_COMMAND) && wstrb_q[0];
  assign data_wr = wr_go && is_word(awaddr_q, OFS_DATA)
                   && state_q == WAIT_WRITE;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q  <= WAIT_CMD;
      target_q <= SEL_STATUS;
    end else if (cmd_wr) begin
      // A write only counts with the enable bit cleared
      if (!wdata_q[CMD_WEN_BIT]) begin
        target_q <= wdata_q[3:0];
        state_q  <= wdata_q[CMD_RD_BIT] ? WAIT_READ : WAIT_WRITE;
      end
    end else if (data_wr || data_rd) begin
      state_q <= WAIT_CMD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register contents

  logic [7:0]  status_q;
  logic [23:0] result_q;
  logic [23:0] test1_q;
  logic [23:0] test2_q;
  logic [23:0] offset_word;
  logic [23:0] gain_word;
  logic [2:0]  cal_slot;
  logic        wr_sel_mode;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      result_q <= RST_RESULT;
    end else if (conv_valid) begin
      result_q <= conv_result;
    end
  end

  // Mode, channel and test words store bits as written; port keeps only bits in 8'h33, filter clamps
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q          <= RST_MODE;
      channel_q       <= RST_CHANNEL;
      port_q          <= RST_PORT;
      decimation_word <= RST_FILTER;
      test1_q         <= RST_TEST;
      test2_q         <= RST_TEST;
    end else if (data_wr) begin
      unique case (target_q)
        SEL_MODE:    mode_q    <= wdata_q[7:0];
        SEL_CHANNEL: channel_q <= wdata_q[7:0];
        SEL_PORT:    port_q    <= wdata_q[7:0] & 8'h33;
        SEL_FILTER: begin
          // Out-of-range words clamp to the least legal value
          decimation_word <= (wdata_q[7:0] < FILTER_MIN) ?
                             FILTER_MIN : wdata_q[7:0];
        end
        SEL_TEST1:   test1_q   <= wdata_q[23:0];
        SEL_TEST2:   test2_q   <= wdata_q[23:0];
        default: begin
        end
      endcase
    end
  end

  // Pseudo-differential mode pairs channels onto one slot
  assign cal_slot = mode_q[MODE_PSEUDO_BIT] ?
                    channel_q[CH_SEL_LSB+3:CH_SEL_LSB+1] :
                    channel_q[CH_SEL_LSB+2:CH_SEL_LSB];
  assign wr_sel_mode = data_wr;

  cal_bank #(
    .DEPTH      (NUM_CAL),
    .RESET_WORD (RST_OFFSET)
  ) u_offset (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .slot    (cal_slot),
    .wr_en   (wr_sel_mode && target_q == SEL_OFFSET),
    .wr_word (wdata_q[23:0]),
    .rd_word (offset_word)
  );

  cal_bank #(
    .DEPTH      (NUM_CAL),
    .RESET_WORD (RST_GAIN)
  ) u_gain (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .slot    (cal_slot),
    .wr_en   (wr_sel_mode && target_q == SEL_GAIN),
    .wr_word (wdata_q[23:0]),
    .rd_word (gain_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write response

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      // Data window without a pending write command is refused
      s_axi_bresp  <= (is_word(awaddr_q, OFS_COMMAND) ||
                       (is_word(awaddr_q, OFS_DATA) &&
                        state_q == WAIT_WRITE)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  function automatic logic [23:0] target_word(input logic [3:0] sel);
    unique case (sel)
      SEL_STATUS:  return {16'h0000, status_q};
      SEL_MODE:    return {16'h0000, mode_q};
      SEL_CHANNEL: return {16'h0000, channel_q};
      SEL_PORT:    return {16'h0000, port_q};
      SEL_FILTER:  return {16'h0000, decimation_word};
      SEL_RESULT:  return result_q;
      SEL_OFFSET:  return offset_word;
      SEL_GAIN:    return gain_word;
      SEL_TEST1:   return test1_q;
      SEL_TEST2:   return test2_q;
      SEL_ID:      return {16'h0000, SILICON_ID};
      default:     return 24'h000000;
    endcase
  endfunction

  logic rd_go;
  assign rd_go   = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign data_rd = rd_go && is_word(rd_addr, OFS_DATA)
                   && state_q == WAIT_READ && !cmd_wr;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (data_rd) begin
        s_axi_rdata <= {8'h00, target_word(target_q)};
      end else if (is_word(rd_addr, OFS_SESSION)) begin
        s_axi_rdata <= {27'h0, target_q,
                        state_q == WAIT_CMD};
      end else if (is_word(rd_addr, OFS_DATA)) begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end else begin
        // Command is write only and reads as zero
        s_axi_rdata <= '0;
        s_axi_rresp <= is_word(rd_addr, OFS_COMMAND) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // adc_register_map_control

// *** test/conv_model.sv ***
// Partner: stands in for the converter core behind the register bank.
// Assumes the bench pulses fire for one cycle per finished conversion.
`timescale 1ns/1ps
module conv_model (
  input  wire logic        clk_sys,
  input  wire logic        fire,
  input  wire logic [23:0] word,
  input  wire logic [7:0]  stat,
  output logic      [23:0] conv_result,
  output logic             conv_valid,
  output logic      [7:0]  status_in
);
  always_ff @(posedge clk_sys) begin
    conv_valid  <= fire;
    // Word is scrambled off the strobe so a stale capture shows
    conv_result <= fire ? word : ~word;
    status_in   <= stat;
  end
endmodule // conv_model

// *** test/adc_regs_chk_assertions.sv ***
// Checker: bus answers and register rules seen at the bank's ports.
// Assumes binding to adc_register_map_control; one clock, sync reset.
`timescale 1ns/1ps
module adc_regs_chk
  import adc_regs_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic [7:0]            mode_q,
  input wire logic [7:0]            port_q,
  input wire logic [7:0]            decimation_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_reset_values: assert property ($fell(sys_rst) |->
    mode_q == RST_MODE && decimation_word == RST_FILTER)
    else $error("reset value wrong");
  a_filter_floor: assert property (
    decimation_word >= FILTER_MIN)
    else $error("decimation word below floor");
  a_port_mask: assert property ((port_q & 8'hCC) == 8'h00)
    else $error("port reserved bits set");
  a_mode_by_write: assert property (!$stable(mode_q) |->
    $rose(s_axi_bvalid)) else $error("mode changed without write");
  a_filter_by_write: assert property (
    !$stable(decimation_word) |-> $rose(s_axi_bvalid))
    else $error("filter changed without write");
  a_write_answer: assert property (
    s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_unmapped_err: assert property ((s_rd_taken and
    (s_axi_araddr == OFS_RESULT_IN)) |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write answered twice");
endmodule // adc_regs_chk
bind adc_register_map_control adc_regs_chk chk (.*);

// *** test/test_adc_register_map_control.sv ***
// Bench: drives the register bank over AXI4-Lite and checks the map.
// Assumes the design package, conv_model and the checker compiled first.
`timescale 1ns/1ps
`define CK(a,b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_adc_register_map_control;
  import adc_regs_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3C;  // Arbitrary value
  logic clk_sys = 1'h0, sys_rst = 1'h1, fire = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, stat = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'hF, cs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [23:0] conv_result, word = 24'h0;
  logic [7:0] status_in, mode_q, channel_q, port_q, decimation_word;
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [31:0] exp_v;
  logic [3:0] sels [6] = '{SEL_MODE, SEL_CHANNEL, SEL_PORT, SEL_FILTER,
                           SEL_OFFSET, SEL_GAIN};
  logic [23:0] rstv [6] = '{24'(RST_MODE), 24'(RST_CHANNEL), 24'(RST_PORT),
                            24'(RST_FILTER), RST_OFFSET, RST_GAIN};
  logic [7:0] wv [4] = '{8'hC3, 8'hFF, 8'h02, 8'hFF};
  logic [7:0] ev [4] = '{8'hC3, 8'h33, 8'h03, 8'hFF};
  logic [3:0] ws [4] = '{SEL_MODE, SEL_PORT, SEL_FILTER, SEL_FILTER};
  adc_register_map_control #(.SILICON_ID(ID_VAL)) uut (.*);
  conv_model pm (.*);
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    resp = s_axi_rresp;
    rd_data = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask
  task automatic put(input logic [3:0] sel, input logic [23:0] d);
    wr(OFS_COMMAND, {28'h0, sel});
    wr(OFS_DATA, {8'h0, d});
  endtask
  task automatic get(input logic [3:0] sel);
    wr(OFS_COMMAND, {24'h0, 4'h4, sel});
    rd(OFS_DATA);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Factory test selects are never written here
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(OFS_SESSION);
    `CK(rd_data[0], 1'h1)
    rd(OFS_DATA);
    `CK({resp, rd_data}, {RESP_SLVERR, 32'h0})
    rd(OFS_RESULT_IN);
    `CK(resp, RESP_SLVERR)
    for (int i = 0; i < 6; i++) begin
      get(sels[i]);
      `CK(rd_data, {8'h0, rstv[i]})
    end
    wr(OFS_COMMAND, 32'h81);
    wr(OFS_DATA, 32'h5);
    `CK({resp, mode_q}, {RESP_SLVERR, 8'h00})
    for (int i = 0; i < 4; i++) begin
      put(ws[i], {16'h0, wv[i]});
      get(ws[i]);
      `CK(rd_data, {24'h0, ev[i]})
    end
    `CK({mode_q, port_q, decimation_word}, 24'hC333FF)
    put(SEL_CHANNEL, 24'h96);
    `CK(channel_q, 8'h96)
    stat <= 8'hA5;
    word <= 24'h123456;
    fire <= 1'h1;
    @(posedge clk_sys);
    fire <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      cs = i == 0 ? SEL_STATUS : i == 1 ? SEL_RESULT : SEL_ID;
      exp_v = i == 0 ? 32'hA5 : i == 1 ? 32'h123456 : 32'(ID_VAL);
      put(cs, 24'h0F0F0F);
      `CK(resp, RESP_OKAY)
      get(cs);
      `CK(rd_data, exp_v)
    end
    for (int k = 0; k < 2; k++) begin
      cs = k == 1 ? SEL_GAIN : SEL_OFFSET;
      put(SEL_MODE, 24'h0);
      put(SEL_CHANNEL, 24'h07);
      put(cs, 24'h111111);
      put(SEL_CHANNEL, 24'h17);
      put(cs, 24'h222222);
      get(cs);
      `CK(rd_data, 32'h222222)
      put(SEL_MODE, 24'h10);
      get(cs);
      `CK(rd_data, 32'h111111)
    end
    // Pending read command, then a mid-run reset drops it
    wr(OFS_COMMAND, {24'h0, 4'h4, SEL_MODE});
    rd(OFS_SESSION);
    `CK(rd_data[4:0], {SEL_MODE, 1'h0})
    sys_rst <= 1'h1;
    // Three edges so stability checks see reset before release
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(OFS_SESSION);
    `CK(rd_data[4:0], {SEL_STATUS, 1'h1})
    `CK({mode_q, decimation_word}, {RST_MODE, RST_FILTER})
    report_and_stop();
  end
endmodule // test_adc_register_map_control
